// file: src/uart_emu_consts.vh
// Function
// - host transmit write sets local pending bit and may interrupt local processor
// - local transmit read of the last byte sets holding-empty now, or after transmit timer if enabled
// - fifo control bits 7:6 pick receive trigger level 1, 4, 8 or 14
// - local fifo control bit 5 flags host change, bit 4 transmit overrun; read clears
// - in fifo mode, fifo control bit 3 selects multi-byte dma mode 1
// - fifo control bit 2 resets transmit fifo; self-clearing, shadow held until local read
// - fifo control bit 1 resets receive fifo; self-clearing, shadow held until local read
// - other fifo control bits take effect only when bit 0 written as 1
// - fifo-enable change flushes all buffers, clears pending interrupts; local may force off
// - modification bit 1 lets overrun write replace last entry, else write ignored
// - modification bit 0 drops daisy enable-out on interrupt, else after acknowledge cycle
// - identification bits 7:6 show fifo mode, 5:4 zero, bit 0 low when pending
// - identification bits 3:1 give highest source: line, trigger/timeout, empty, modem
// - line clears on status read, trigger below level, timeout on fifo read, modem externally
// - holding-empty interrupt clears on host transmit write or identification read reporting it
// - identification contents frozen during host read; new events recorded meanwhile
// - line status bit 7 zero in buffer mode, else set while fifo holds error bytes
// - local processor writes transmitter-empty, except automatic in double-buffer mode
// - holding-empty set on empty, delayed to host by timer, not local; host write clears
// - local error bits go to shadow, copied with next byte, shown to host at head
// - overrun sets on receive write to full buffer; data dropped; host status read clears
// - data-ready set on receive write, host copy timer-delayed; both clear when all read
`ifndef UART_EMU_CONSTS_VH
`define UART_EMU_CONSTS_VH
`define H_DATA      3'h0
`define H_IER       3'h1
`define H_FIFO      3'h2
`define H_LSR       3'h5
`define L_FIFO      8'hE9
`define L_DATA      8'hF0
`define L_IER       8'hF1
`define L_LSR       8'hF5
`define B_EN        0
`define B_RXRST     1
`define B_TXRST     2
`define B_DMA       3
`define B_TRANSMITTER_EMPTY      6
`define B_OVW       1
`define B_FAST      0
`define TRIG_1      5'h01
`define TRIG_4      5'h04
`define TRIG_8      5'h08
`define TRIG_14     5'h0E
`define ID_LINE     3'h3
`define ID_RDA      3'h2
`define ID_TMO      3'h6
`define ID_HOLDING_EMPTY     3'h1
`define ID_MODEM    3'h0
`define IRQ_RDA     0
`define IRQ_HOLDING_EMPTY    1
`define IRQ_LINE    2
`define IRQ_MODEM   3
`define LIRQ_THR    0
`define LIRQ_FIFO   1
`endif

// file: src/emu_fifo_ram.v
`timescale 1ns/1ps
// small two-port store; read data registered from the addressed word
module emu_fifo_ram #(
  parameter W  = 8,
  parameter AW = 4
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [W-1:0]  i_wdata,
  input  wire [AW-1:0] i_raddr,
  output reg  [W-1:0]  o_rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= {W{1'b0}};
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // emu_fifo_ram

// file: src/host_uart_emu.v
`timescale 1ns/1ps
`include "uart_emu_consts.vh"
module host_uart_emu #(
  parameter AW    = 4,
  parameter DEPTH = 16
) (
  input  wire       I_CLK_SYS,
  input  wire       I_RST_N,
  input  wire [2:0] I_HOST_ADDR,
  input  wire       I_HOST_RD,
  input  wire       I_HOST_WR,
  input  wire [7:0] I_HOST_WDATA,
  output reg  [7:0] O_HOST_RDATA,
  output wire       O_HOST_INT,
  output wire       O_DMA_MODE,
  input  wire [7:0] I_LOC_ADDR,
  input  wire       I_LOC_RD,
  input  wire       I_LOC_WR,
  input  wire [7:0] I_LOC_WDATA,
  output reg  [7:0] O_LOC_RDATA,
  output wire       O_LOC_INT,
  input  wire [1:0] I_LOC_IRQ_EN,
  input  wire [3:0] I_IRQ_ENABLE,
  input  wire       I_MODEM_INT,
  input  wire       I_FORCE_NOFIFO,
  input  wire       I_DOUBLE_BUF,
  input  wire       I_TX_TIMER_EN,
  input  wire       I_TX_TIMER_DONE,
  input  wire       I_RX_TIMER_EN,
  input  wire       I_RX_TIMER_DONE,
  input  wire       I_RX_TIMEOUT,
  output reg        O_TX_TIMER_START,
  output reg        O_RX_TIMER_START,
  input  wire       I_DAISY_EN_IN,
  input  wire       I_INTERRUPT_ACKNOWLEDGE_CYCLE,
  output wire       O_DAISY_EN_OUT
);
  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] ONE  = 1;

  function [4:0] trig_bytes;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    trig_bytes = `TRIG_1;
        2'h1:    trig_bytes = `TRIG_4;
        2'h2:    trig_bytes = `TRIG_8;
        default: trig_bytes = `TRIG_14;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // state
  reg          fifo_en;
  reg  [1:0]   trig;
  reg          dma_sel;
  reg          txr_sh;
  reg          rxr_sh;
  reg          fcr_chg;
  reg          tx_ovr;
  reg          thr_pend;
  reg          mod_ovw;
  reg          mod_fast;
  reg          transmitter_empty;
  reg  [2:0]   err_sh;
  reg  [2:0]   err_host;
  reg          ovr;
  reg          dr_host;
  reg          holding_empty_host;
  reg          holding_empty_int;
  reg          tmo_int;
  reg          ack_blk;
  reg  [3:0]   iir_q;
  reg  [AW-1:0] twp;
  reg  [AW-1:0] trp;
  reg  [AW:0]   tcnt;
  reg  [AW-1:0] rwp;
  reg  [AW-1:0] rrp;
  reg  [AW:0]   rcnt;
  reg  [AW:0]   errcnt;
  reg          fresh1;
  reg          fresh2;
  wire [7:0]   tx_head;
  wire [10:0]  rx_head;

  //////////////////////////////////////////////////////////////////////////
  // access decode
  wire h_thr_wr = I_HOST_WR & (I_HOST_ADDR == `H_DATA);
  wire h_fcr_wr = I_HOST_WR & (I_HOST_ADDR == `H_FIFO);
  wire h_rbr_rd = I_HOST_RD & (I_HOST_ADDR == `H_DATA);
  wire h_iir_rd = I_HOST_RD & (I_HOST_ADDR == `H_FIFO);
  wire h_lsr_rd = I_HOST_RD & (I_HOST_ADDR == `H_LSR);
  wire l_fcr_rd = I_LOC_RD & (I_LOC_ADDR == `L_FIFO);
  wire l_mod_wr = I_LOC_WR & (I_LOC_ADDR == `L_FIFO);
  wire l_thr_rd = I_LOC_RD & (I_LOC_ADDR == `L_DATA);
  wire l_rbr_wr = I_LOC_WR & (I_LOC_ADDR == `L_DATA);
  wire l_lsr_wr = I_LOC_WR & (I_LOC_ADDR == `L_LSR);

  // bit 0 lands unless the local force-off holds it clear; the rest only with bit 0 set
  wire fcr_go  = h_fcr_wr & I_HOST_WDATA[`B_EN];
  wire new_en  = I_HOST_WDATA[`B_EN] & ~I_FORCE_NOFIFO;
  wire flush   = (h_fcr_wr & (new_en != fifo_en))
               | (I_FORCE_NOFIFO & fifo_en);
  wire tx_clr  = flush | (fcr_go & I_HOST_WDATA[`B_TXRST]);
  wire rx_clr  = flush | (fcr_go & I_HOST_WDATA[`B_RXRST]);

  //////////////////////////////////////////////////////////////////////////
  // fifo movement; capacity one in buffer mode
  wire [AW:0] cap = fifo_en ? FULL : ONE;
  wire tx_full = (tcnt == cap);
  wire tx_push = h_thr_wr & ~tx_full & ~tx_clr;
  wire tx_pop  = l_thr_rd & (tcnt != 0) & ~tx_clr;
  wire rx_full = (rcnt == cap);
  wire rx_over = l_rbr_wr & rx_full & ~rx_clr;
  // overwrite path leaves the error tally alone: old flags are not known here
  wire rx_ovw  = rx_over & mod_ovw;
  wire rx_push = l_rbr_wr & ~rx_full & ~rx_clr;
  wire rx_pop  = h_rbr_rd & (rcnt != 0) & ~rx_clr;
  wire [AW-1:0] rx_waddr = rx_ovw ? rwp - ONE[AW-1:0] : rwp;

  emu_fifo_ram #(.W(8), .AW(AW)) u_tx_ram (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_we    (tx_push),
    .i_waddr (twp),
    .i_wdata (I_HOST_WDATA),
    .i_raddr (trp),
    .o_rdata (tx_head)
  );

  emu_fifo_ram #(.W(11), .AW(AW)) u_rx_ram (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_we    (rx_push | rx_ovw),
    .i_waddr (rx_waddr),
    .i_wdata ({err_sh, I_LOC_WDATA}),
    .i_raddr (rrp),
    .o_rdata (rx_head)
  );

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      twp  <= {AW{1'b0}};
      trp  <= {AW{1'b0}};
      tcnt <= {(AW+1){1'b0}};
    end else if (tx_clr) begin
      twp  <= {AW{1'b0}};
      trp  <= {AW{1'b0}};
      tcnt <= {(AW+1){1'b0}};
    end else begin
      if (tx_push) begin
        twp <= twp + ONE[AW-1:0];
      end
      if (tx_pop) begin
        trp <= trp + ONE[AW-1:0];
      end
      if (tx_push & ~tx_pop) begin
        tcnt <= tcnt + ONE;
      end else if (tx_pop & ~tx_push) begin
        tcnt <= tcnt - ONE;
      end
    end
  end

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rwp    <= {AW{1'b0}};
      rrp    <= {AW{1'b0}};
      rcnt   <= {(AW+1){1'b0}};
      errcnt <= {(AW+1){1'b0}};
    end else if (rx_clr) begin
      rwp    <= {AW{1'b0}};
      rrp    <= {AW{1'b0}};
      rcnt   <= {(AW+1){1'b0}};
      errcnt <= {(AW+1){1'b0}};
    end else begin
      if (rx_push) begin
        rwp <= rwp + ONE[AW-1:0];
      end
      if (rx_pop) begin
        rrp <= rrp + ONE[AW-1:0];
      end
      if (rx_push & ~rx_pop) begin
        rcnt <= rcnt + ONE;
      end else if (rx_pop & ~rx_push) begin
        rcnt <= rcnt - ONE;
      end
      if ((rx_push & |err_sh) & ~(rx_pop & |rx_head[10:8])) begin
        errcnt <= errcnt + ONE;
      end else if (~(rx_push & |err_sh) & rx_pop & |rx_head[10:8] & (errcnt != 0)) begin
        errcnt <= errcnt - ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control and status flags
  wire holding_empty_set = (tx_pop & (tcnt == ONE) & ~tx_push & ~I_TX_TIMER_EN)
                | (I_TX_TIMER_DONE & (tcnt == 0) & ~tx_push)
                | (tx_clr & ~holding_empty_host);
  wire dr_set   = (rx_push & ~I_RX_TIMER_EN)
                | (I_RX_TIMER_DONE & (rcnt != 0));
  wire dr_clr   = rx_clr | (rx_pop & (rcnt == ONE) & ~rx_push);
  // new head becomes visible one edge after the pointer moves
  wire head_new = (rx_pop & (rcnt > ONE)) | (rx_push & (rcnt == 0));

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fifo_en   <= 1'b0;
      trig      <= 2'h0;
      dma_sel   <= 1'b0;
      txr_sh    <= 1'b0;
      rxr_sh    <= 1'b0;
      fcr_chg   <= 1'b0;
      tx_ovr    <= 1'b0;
      thr_pend  <= 1'b0;
      mod_ovw   <= 1'b0;
      mod_fast  <= 1'b0;
      transmitter_empty      <= 1'b1;
      err_sh    <= 3'h0;
      err_host  <= 3'h0;
      ovr       <= 1'b0;
      dr_host   <= 1'b0;
      holding_empty_host <= 1'b1;
      holding_empty_int  <= 1'b0;
      tmo_int   <= 1'b0;
      fresh1    <= 1'b0;
      fresh2    <= 1'b0;
    end else begin
      if (h_fcr_wr) begin
        fifo_en <= new_en;
      end else if (I_FORCE_NOFIFO) begin
        fifo_en <= 1'b0;
      end
      if (fcr_go) begin
        trig    <= I_HOST_WDATA[7:6];
        dma_sel <= I_HOST_WDATA[`B_DMA];
      end
      // flags set by the host win over a local read in the same cycle
      if (fcr_go & I_HOST_WDATA[`B_TXRST]) begin
        txr_sh <= 1'b1;
      end else if (l_fcr_rd) begin
        txr_sh <= 1'b0;
      end
      if (fcr_go & I_HOST_WDATA[`B_RXRST]) begin
        rxr_sh <= 1'b1;
      end else if (l_fcr_rd) begin
        rxr_sh <= 1'b0;
      end
      if (h_fcr_wr) begin
        fcr_chg <= 1'b1;
      end else if (l_fcr_rd) begin
        fcr_chg <= 1'b0;
      end
      if (h_thr_wr & tx_full & ~tx_clr) begin
        tx_ovr <= 1'b1;
      end else if (l_fcr_rd) begin
        tx_ovr <= 1'b0;
      end
      if (h_thr_wr) begin
        thr_pend <= 1'b1;
      end else if (l_thr_rd) begin
        thr_pend <= 1'b0;
      end
      if (l_mod_wr) begin
        mod_ovw  <= I_LOC_WDATA[`B_OVW];
        mod_fast <= I_LOC_WDATA[`B_FAST];
      end
      if (I_DOUBLE_BUF) begin
        transmitter_empty <= (tcnt == 0) & holding_empty_host;
      end else if (l_lsr_wr) begin
        transmitter_empty <= I_LOC_WDATA[`B_TRANSMITTER_EMPTY];
      end
      if (l_lsr_wr) begin
        err_sh <= I_LOC_WDATA[4:2];
      end else if (l_rbr_wr) begin
        err_sh <= 3'h0;
      end
      fresh1 <= head_new;
      fresh2 <= fresh1 & ~rx_clr;
      if (fresh2 & (rcnt != 0)) begin
        err_host <= err_host | rx_head[10:8];
      end else if (h_lsr_rd | flush) begin
        err_host <= 3'h0;
      end
      if (rx_over) begin
        ovr <= 1'b1;
      end else if (h_lsr_rd | flush) begin
        ovr <= 1'b0;
      end
      if (dr_set & ~dr_clr) begin
        dr_host <= 1'b1;
      end else if (dr_clr) begin
        dr_host <= 1'b0;
      end
      if (holding_empty_set) begin
        holding_empty_host <= 1'b1;
      end else if (h_thr_wr) begin
        holding_empty_host <= 1'b0;
      end
      if (holding_empty_set & ~flush) begin
        holding_empty_int <= 1'b1;
      end else if (h_thr_wr | flush | (h_iir_rd & (iir_q[3:1] == `ID_HOLDING_EMPTY) & ~iir_q[0])) begin
        holding_empty_int <= 1'b0;
      end
      if (I_RX_TIMEOUT & fifo_en & (rcnt != 0) & ~flush) begin
        tmo_int <= 1'b1;
      end else if (rx_pop | flush) begin
        tmo_int <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host interrupt priority
  wire       line_src = I_IRQ_ENABLE[`IRQ_LINE] & (ovr | |err_host);
  wire       lvl_hit  = fifo_en ? (rcnt >= trig_bytes(trig)) : 1'b1;
  wire       rda_src  = I_IRQ_ENABLE[`IRQ_RDA] & dr_host & lvl_hit;
  wire       tmo_src  = I_IRQ_ENABLE[`IRQ_RDA] & tmo_int;
  wire       holding_empty_src = I_IRQ_ENABLE[`IRQ_HOLDING_EMPTY] & holding_empty_int;
  wire       mdm_src  = I_IRQ_ENABLE[`IRQ_MODEM] & I_MODEM_INT;
  reg  [2:0] next_id;

  always @* begin
    if (line_src) begin
      next_id = `ID_LINE;
    end else if (rda_src) begin
      next_id = `ID_RDA;
    end else if (tmo_src) begin
      next_id = `ID_TMO;
    end else if (holding_empty_src) begin
      next_id = `ID_HOLDING_EMPTY;
    end else begin
      next_id = `ID_MODEM;
    end
  end

  wire any_src = line_src | rda_src | tmo_src | holding_empty_src | mdm_src;
  assign O_HOST_INT = any_src;
  assign O_DMA_MODE = fifo_en & dma_sel;

  // snapshot held while the host reads it; live sources keep collecting
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      iir_q <= 4'h1;
    end else if (!h_iir_rd) begin
      iir_q <= {next_id, ~any_src};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // local interrupt and daisy chain
  assign O_LOC_INT = (thr_pend & I_LOC_IRQ_EN[`LIRQ_THR])
                   | ((fcr_chg | tx_ovr) & I_LOC_IRQ_EN[`LIRQ_FIFO]);

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_blk <= 1'b0;
    end else if (I_INTERRUPT_ACKNOWLEDGE_CYCLE & O_LOC_INT) begin
      ack_blk <= 1'b1;
    end else if (!O_LOC_INT) begin
      ack_blk <= 1'b0;
    end
  end

  // slow mode lets a lower chain member answer an acknowledge it should not
  assign O_DAISY_EN_OUT = I_DAISY_EN_IN & ~(mod_fast ? O_LOC_INT : ack_blk);

  //////////////////////////////////////////////////////////////////////////
  // read data
  wire       lsr7     = fifo_en & (errcnt != 0);
  wire [7:0] fcr_loc  = {trig, fcr_chg, tx_ovr, dma_sel, txr_sh, rxr_sh, fifo_en};
  wire [7:0] lsr_host = {lsr7, transmitter_empty, holding_empty_host, err_host, ovr, dr_host};
  wire [7:0] lsr_loc  = {lsr7, transmitter_empty, (tcnt == 0), err_sh, ovr, (rcnt != 0)};
  wire [7:0] iir_rd   = {fifo_en, fifo_en, 2'h0, iir_q};

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HOST_RDATA     <= 8'h00;
      O_LOC_RDATA      <= 8'h00;
      O_TX_TIMER_START <= 1'b0;
      O_RX_TIMER_START <= 1'b0;
    end else begin
      O_TX_TIMER_START <= tx_pop & I_TX_TIMER_EN;
      O_RX_TIMER_START <= rx_push & I_RX_TIMER_EN;
      if (I_HOST_RD) begin
        case (I_HOST_ADDR)
          `H_DATA: O_HOST_RDATA <= (rcnt != 0) ? rx_head[7:0] : 8'h00;
          `H_IER:  O_HOST_RDATA <= {4'h0, I_IRQ_ENABLE};
          `H_FIFO: O_HOST_RDATA <= iir_rd;
          `H_LSR:  O_HOST_RDATA <= lsr_host;
          default: O_HOST_RDATA <= 8'h00;
        endcase
      end
      if (I_LOC_RD) begin
        case (I_LOC_ADDR)
          `L_FIFO: O_LOC_RDATA <= fcr_loc;
          `L_DATA: O_LOC_RDATA <= (tcnt != 0) ? tx_head : 8'h00;
          `L_IER:  O_LOC_RDATA <= {4'h0, I_IRQ_ENABLE};
          `L_LSR:  O_LOC_RDATA <= lsr_loc;
          default: O_LOC_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // host_uart_emu

// file: bench/host_uart_emu_properties.sv
`timescale 1ns/1ps
`include "uart_emu_consts.vh"
module host_uart_emu_properties (
  input wire       I_CLK_SYS,
  input wire       I_RST_N,
  input wire [2:0] I_HOST_ADDR,
  input wire       I_HOST_RD,
  input wire       I_HOST_WR,
  input wire [7:0] I_HOST_WDATA,
  input wire [7:0] O_HOST_RDATA,
  input wire       O_HOST_INT,
  input wire       O_DMA_MODE,
  input wire [7:0] I_LOC_ADDR,
  input wire       I_LOC_RD,
  input wire       I_LOC_WR,
  input wire [7:0] I_LOC_WDATA,
  input wire [7:0] O_LOC_RDATA,
  input wire       O_LOC_INT,
  input wire [1:0] I_LOC_IRQ_EN,
  input wire       I_FORCE_NOFIFO,
  input wire       I_TX_TIMER_EN,
  input wire       O_TX_TIMER_START,
  input wire       O_DAISY_EN_OUT
);
  reg  fifo_on;
  reg  fast;
  wire h_data_wr = I_HOST_WR && (I_HOST_ADDR == `H_DATA);
  wire h_id_rd   = I_HOST_RD && (I_HOST_ADDR == `H_FIFO);
  wire h_lsr_rd  = I_HOST_RD && (I_HOST_ADDR == `H_LSR);
  wire l_fcr_rd  = I_LOC_RD && (I_LOC_ADDR == `L_FIFO);
  wire l_tx_rd   = I_LOC_RD && (I_LOC_ADDR == `L_DATA) && I_TX_TIMER_EN;
  ////////////////////////////////////////////////////////////////
  // mode bits rebuilt from bus traffic and the force-off input, never from the design
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fifo_on <= 1'h0;
      fast    <= 1'h0;
    end else begin
      if (I_HOST_WR && (I_HOST_ADDR == `H_FIFO))
        fifo_on <= I_HOST_WDATA[0] & ~I_FORCE_NOFIFO;
      else if (I_FORCE_NOFIFO)
        fifo_on <= 1'h0;
      if (I_LOC_WR && (I_LOC_ADDR == `L_FIFO))
        fast <= I_LOC_WDATA[0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  AST_LOC_INT_ON_TX_WRITE:
    assert property (h_data_wr && I_LOC_IRQ_EN[0] |=> O_LOC_INT) else $error("no local interrupt after tx write");
  AST_TX_TIMER_CAUSE:
    assert property (O_TX_TIMER_START |-> $past(l_tx_rd)) else $error("tx timer start without local read");
  AST_DMA_NEEDS_FIFO:
    assert property (O_DMA_MODE |-> fifo_on) else $error("dma mode 1 outside fifo mode");
  AST_IDENT_FIELDS:
    assert property (h_id_rd |=> O_HOST_RDATA[5:4] == 2'h0 && O_HOST_RDATA[7:6] == {2{$past(fifo_on)}}
      && O_HOST_RDATA[0] == !$past(O_HOST_INT, 2)) else $error("ident fields wrong");
  AST_OVERRUN_CLEARED:
    assert property ((h_lsr_rd && !I_LOC_WR) ##1 !I_LOC_WR ##1 (h_lsr_rd && !I_LOC_WR) |=> !O_HOST_RDATA[1])
      else $error("overrun kept after status read");
  AST_HOLDING_EMPTY_CLEARED:
    assert property ((h_data_wr && !I_LOC_RD) ##1 (!I_LOC_RD && !I_HOST_WR) ##1 (h_lsr_rd && !I_LOC_RD)
      |=> !O_HOST_RDATA[5]) else $error("holding empty kept after tx write");
  AST_DAISY_FAST:
    assert property (fast && O_LOC_INT |-> !O_DAISY_EN_OUT) else $error("enable out high with fast mode");
  AST_LOC_FLAGS_CLEARED:
    assert property ((l_fcr_rd && !I_HOST_WR) ##1 !I_HOST_WR ##1 (l_fcr_rd && !I_HOST_WR)
      |=> O_LOC_RDATA[5:4] == 2'h0 && O_LOC_RDATA[2:1] == 2'h0) else $error("local fifo flags not cleared");
  COV_TRIGGER: cover property (O_HOST_INT && fifo_on);
  COV_DMA: cover property (O_DMA_MODE);
  COV_TX_TIMER: cover property (O_TX_TIMER_START);
endmodule // host_uart_emu_properties

bind host_uart_emu host_uart_emu_properties u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_HOST_ADDR(I_HOST_ADDR), .I_HOST_RD(I_HOST_RD),
  .I_HOST_WR(I_HOST_WR), .I_HOST_WDATA(I_HOST_WDATA), .O_HOST_RDATA(O_HOST_RDATA), .O_HOST_INT(O_HOST_INT),
  .O_DMA_MODE(O_DMA_MODE), .I_LOC_ADDR(I_LOC_ADDR), .I_LOC_RD(I_LOC_RD), .I_LOC_WR(I_LOC_WR),
  .I_LOC_WDATA(I_LOC_WDATA), .O_LOC_RDATA(O_LOC_RDATA), .O_LOC_INT(O_LOC_INT), .I_LOC_IRQ_EN(I_LOC_IRQ_EN),
  .I_FORCE_NOFIFO(I_FORCE_NOFIFO), .I_TX_TIMER_EN(I_TX_TIMER_EN), .O_TX_TIMER_START(O_TX_TIMER_START),
  .O_DAISY_EN_OUT(O_DAISY_EN_OUT)
);

// file: bench/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model #(
  parameter AW = 3
) (
  input  wire          i_clk,
  input  wire [7:0]    i_rdata,
  output reg  [AW-1:0] o_addr,
  output reg           o_rd,
  output reg           o_wr,
  output reg  [7:0]    o_wdata
);
  initial begin
    o_addr  = {AW{1'h0}};
    o_rd    = 1'h0;
    o_wr    = 1'h0;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // spare edge after the strobe drops, so a back-to-back call never re-drives it
  task wr(input [AW-1:0] a, input [7:0] v);
    begin
      o_addr  <= a;
      o_wdata <= v;
      o_wr    <= 1'h1;
      @(posedge i_clk);
      o_wr <= 1'h0;
      @(posedge i_clk);
    end
  endtask
  // write data is not held during reads: inverted so stale bytes never look valid
  task rd(input [AW-1:0] a, output [7:0] v);
    begin
      o_addr  <= a;
      o_wdata <= ~o_wdata;
      o_rd    <= 1'h1;
      @(posedge i_clk);
      o_rd <= 1'h0;
      @(posedge i_clk);
      v = i_rdata;
    end
  endtask
endmodule // host_bus_model

// file: bench/host_uart_emu_test.sv
`timescale 1ns/1ps
`include "uart_emu_consts.vh"
`define CHK(got, exp, msg) begin \
  tests_run = tests_run + 1; \
  if ((got) !== (exp)) begin \
    n_errors = n_errors + 1; \
    $display("ERROR t=%0t %s: got %h, expected %h", $time, msg, got, exp); \
  end \
end
module host_uart_emu_test;
  reg         clk;
  reg         rst_n;
  reg  [1:0]  loc_irq_en;
  reg  [3:0]  irq_en;
  reg         modem;
  reg         force_off;
  reg         tx_en;
  reg         tx_done;
  reg         daisy_in;
  reg         dbuf;
  reg         interrupt_acknowledge_cycle;
  wire [2:0]  h_addr;
  wire        h_rd;
  wire        h_wr;
  wire [7:0]  h_wdata;
  wire [7:0]  h_rdata;
  wire        h_int;
  wire        dma;
  wire [7:0]  l_addr;
  wire        l_rd;
  wire        l_wr;
  wire [7:0]  l_wdata;
  wire [7:0]  l_rdata;
  wire        l_int;
  wire        tx_start;
  wire        daisy_out;
  reg  [7:0]  d;
  reg  [16:0] rows [0:3];
  reg  [4:0]  lvl [0:3];
  integer     i;
  integer     j;
  integer     n_errors;
  integer     tests_run;

  host_uart_emu dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HOST_ADDR(h_addr), .I_HOST_RD(h_rd), .I_HOST_WR(h_wr),
    .I_HOST_WDATA(h_wdata), .O_HOST_RDATA(h_rdata), .O_HOST_INT(h_int), .O_DMA_MODE(dma),
    .I_LOC_ADDR(l_addr), .I_LOC_RD(l_rd), .I_LOC_WR(l_wr), .I_LOC_WDATA(l_wdata), .O_LOC_RDATA(l_rdata),
    .O_LOC_INT(l_int), .I_LOC_IRQ_EN(loc_irq_en), .I_IRQ_ENABLE(irq_en), .I_MODEM_INT(modem),
    .I_FORCE_NOFIFO(force_off), .I_DOUBLE_BUF(dbuf), .I_TX_TIMER_EN(tx_en), .I_TX_TIMER_DONE(tx_done),
    .I_RX_TIMER_EN(1'h0), .I_RX_TIMER_DONE(1'h0), .I_RX_TIMEOUT(1'h0), .O_TX_TIMER_START(tx_start),
    .O_RX_TIMER_START(), .I_DAISY_EN_IN(daisy_in), .I_INTERRUPT_ACKNOWLEDGE_CYCLE(interrupt_acknowledge_cycle), .O_DAISY_EN_OUT(daisy_out)
  );
  host_bus_model #(.AW(3)) u_host (
    .i_clk(clk), .i_rdata(h_rdata), .o_addr(h_addr), .o_rd(h_rd), .o_wr(h_wr), .o_wdata(h_wdata)
  );
  // the local processor speaks the same strobe protocol
  host_bus_model #(.AW(8)) u_loc (
    .i_clk(clk), .i_rdata(l_rdata), .o_addr(l_addr), .o_rd(l_rd), .o_wr(l_wr), .o_wdata(l_wdata)
  );
  ////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors = n_errors + 1;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, modem, force_off, tx_en, tx_done, dbuf, interrupt_acknowledge_cycle, loc_irq_en, irq_en} = 13'h0000;
    daisy_in = 1'h1;
    n_errors = 0;
    tests_run = 0;
    // fcr write, expected local fifo control view, expected dma mode
    rows[0] = {8'h01, 8'h21, 1'h0};
    rows[1] = {8'h49, 8'h69, 1'h1};
    rows[2] = {8'h87, 8'hA7, 1'h0};
    rows[3] = {8'hC1, 8'hE1, 1'h0};
    lvl[0] = `TRIG_1;
    lvl[1] = `TRIG_4;
    lvl[2] = `TRIG_8;
    lvl[3] = `TRIG_14;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'h60, "line status after reset")
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'h01, "ident after reset")
    for (i = 0; i < 4; i = i + 1) begin
      u_host.wr(`H_FIFO, rows[i][16:9]);
      u_loc.rd(`L_FIFO, d);
      `CHK(d, rows[i][8:1], "local fifo control view")
      `CHK(dma, rows[i][0], "dma mode")
      u_loc.rd(`L_FIFO, d);
      `CHK(d & 8'h36, 8'h00, "local flags and shadows cleared")
      u_host.rd(`H_FIFO, d);
      `CHK(d, 8'hC1, "ident in fifo mode")
    end
    // error byte: parity shadow rides with the next byte, transmitter_empty kept set
    irq_en <= 4'h5;
    // pending fifo-control change drives the local interrupt seen by the chain
    loc_irq_en <= 2'h2;
    u_loc.wr(`L_FIFO, 8'h01);
    u_host.wr(`H_FIFO, 8'h03);
    u_loc.wr(`L_LSR, 8'h44);
    u_loc.wr(`L_DATA, 8'hA5);
    repeat (4) @(posedge clk);
    `CHK(daisy_out, 1'h0, "enable out in fast mode")
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'hC6, "line error outranks data")
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'hE5, "error bits at fifo head")
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'hE1, "fifo error flag held")
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'hC4, "trigger source after status read")
    u_host.rd(`H_DATA, d);
    `CHK(d, 8'hA5, "receive data")
    repeat (2) @(posedge clk);
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'h60, "fifo drained")
    // transmit path with the character timer in use
    loc_irq_en <= 2'h1;
    tx_en <= 1'h1;
    irq_en <= 4'h2;
    u_host.wr(`H_DATA, 8'h5A);
    `CHK(l_int, 1'h1, "local interrupt on host write")
    u_host.rd(`H_LSR, d);
    `CHK(d[5], 1'h0, "holding empty cleared")
    u_loc.rd(`L_DATA, d);
    `CHK(d, 8'h5A, "transmit data")
    `CHK(tx_start, 1'h1, "timer start pulse")
    u_loc.rd(`L_LSR, d);
    `CHK(d[5], 1'h1, "local copy not delayed")
    u_host.rd(`H_LSR, d);
    `CHK(d[5], 1'h0, "host copy waits for timer")
    tx_done <= 1'h1;
    @(posedge clk);
    tx_done <= 1'h0;
    repeat (2) @(posedge clk);
    u_host.rd(`H_LSR, d);
    `CHK(d[5], 1'h1, "host copy after timer")
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'hC2, "holding empty source")
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'hC1, "ident read clears it")
    // every trigger code: one byte short stays quiet, the next one fires
    irq_en <= 4'h1;
    for (i = 0; i < 4; i = i + 1) begin
      u_host.wr(`H_FIFO, {i[1:0], 6'h03});
      for (j = 1; j < lvl[i]; j = j + 1)
        u_loc.wr(`L_DATA, j[7:0]);
      repeat (2) @(posedge clk);
      `CHK(h_int, 1'h0, "below trigger level")
      u_loc.wr(`L_DATA, 8'hFF);
      repeat (2) @(posedge clk);
      `CHK(h_int, 1'h1, "at trigger level")
    end
    for (j = 0; j < 3; j = j + 1)
      u_loc.wr(`L_DATA, 8'h77);
    repeat (2) @(posedge clk);
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'h63, "overrun on full fifo")
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'h61, "overrun cleared by read")
    u_host.wr(`H_FIFO, 8'h00);
    u_host.rd(`H_LSR, d);
    `CHK(d, 8'h60, "flush on fifo disable")
    force_off <= 1'h1;
    u_host.wr(`H_FIFO, 8'h01);
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'h01, "fifo mode held off locally")
    modem <= 1'h1;
    irq_en <= 4'h8;
    // snapshot is taken the edge before the read, so let the source settle
    @(posedge clk);
    u_host.rd(`H_FIFO, d);
    `CHK(d, 8'h00, "modem source")
    modem <= 1'h0;
    // slow chain mode and automatic transmitter-empty
    u_loc.wr(`L_FIFO, 8'h00);
    dbuf <= 1'h1;
    u_host.wr(`H_DATA, 8'h3C);
    `CHK(daisy_out, 1'h1, "slow mode waits for acknowledge")
    interrupt_acknowledge_cycle <= 1'h1;
    @(posedge clk);
    interrupt_acknowledge_cycle <= 1'h0;
    @(posedge clk);
    `CHK(daisy_out, 1'h0, "enable out after acknowledge")
    u_host.rd(`H_LSR, d);
    `CHK(d[6], 1'h0, "transmitter empty follows fifo")
    end_sim;
  end
endmodule // host_uart_emu_test
